// file: include/awcu_pkg.sv
// constants and types shared by the pio write command unit
package awcu_pkg;
   // ----------------------------------------------------------------
   // register word indexes (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam logic [3:0] IDX_DATA   = 4'h0;
   localparam logic [3:0] IDX_FEAT   = 4'h1;
   localparam logic [3:0] IDX_SCNT   = 4'h2;
   localparam logic [3:0] IDX_SNUM   = 4'h3;
   localparam logic [3:0] IDX_CYLL   = 4'h4;
   localparam logic [3:0] IDX_CYLH   = 4'h5;
   localparam logic [3:0] IDX_DEVH   = 4'h6;
   localparam logic [3:0] IDX_CMD    = 4'h7;
   localparam logic [3:0] IDX_DCTL   = 4'h8;
   localparam logic [3:0] IDX_BLKSZ  = 4'h9;
   localparam logic [3:0] IDX_ISTAT  = 4'ha;
   localparam logic [3:0] IDX_IMASK  = 4'hb;
   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_WR_SECT     = 8'h30;
   localparam logic [7:0] CMD_WR_MULT_FUA = 8'hce;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ST_BSY  = 7;
   localparam int ST_RDY  = 6;
   localparam int ST_DSC  = 4;
   localparam int ST_DRQ  = 3;
   localparam int ST_ERR  = 0;
   localparam int ER_IDN  = 4;
   localparam int ER_ABT  = 2;
   localparam int DH_LBA  = 6;
   localparam int DC_HOB  = 7;
   localparam int IRQ_DRQ = 0;
   localparam int IRQ_END = 1;
   localparam int IRQ_ERR = 2;
   // ----------------------------------------------------------------
   // reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_DEVH      = 8'ha0;
   localparam logic [7:0]  RST_BLKSZ     = 8'h01;
   localparam logic [2:0]  RST_IMASK     = 3'h0;
   localparam logic [7:0]  WORDS_LAST    = 8'hff;
   localparam logic [16:0] SECT_ZERO_STD = 17'h00100;
   localparam logic [16:0] SECT_ZERO_EXT = 17'h10000;
   localparam logic [7:0]  CHS_SPT       = 8'h3f;
   localparam logic [3:0]  CHS_HEAD_LAST = 4'hf;
   // ----------------------------------------------------------------
   // command sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PREP,
      ST_XFER,
      ST_COMMIT,
      ST_FLUSH,
      ST_FINISH
   } awcu_state_e;
endpackage

// file: logic/awcu_top.sv
// drive-side pio write command unit with wishbone task-file access
// Notes on behaviour
// - command ceh is extended fua multiple pio write
// - fua write flushes media before ending status
// - multiple write interrupts once per block
// - sector data arrives as 16-bit data words
// - extended count 16 bits, zero means 65536
// - 48-bit address from current and previous bytes
// - extended error reports failing address, hob selects
// - codes 30h and 31h both write sectors
// - retry bit changes nothing
// - basic count 8 bits, zero means 256
// - basic write stops at failing sector
// - lba mode takes bits 24-27 from head nibble
// - cylinder registers carry address bits 8-23
// - ending count shows sectors not transferred
// - ending address is last transferred sector
`timescale 1ns/1ns
`default_nettype none
module awcu_top (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq_o,
   output logic      [15:0] med_wdata_o,
   output logic             med_wvalid_o,
   output logic             med_wr_o,
   output logic      [47:0] med_lba_o,
   input  wire logic        med_done_i,
   input  wire logic        med_err_i,
   output logic             med_flush_o,
   input  wire logic        med_flush_done_i
);
   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   logic        ack_ff;
   logic [31:0] rdat_ff;
   logic        bus_req;
   logic        bus_wr;
   logic [3:0]  idx;

   assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign bus_wr   = bus_req & wb_we_i & wb_sel_i[0];
   assign idx      = wb_adr_i[5:2];
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_ff <= 1'b0;
      else
         ack_ff <= bus_req;
   end

   // ----------------------------------------------------------------
   // task-file state
   // ----------------------------------------------------------------
   awcu_pkg::awcu_state_e state_ff;
   logic [7:0]  cur_ff [5];
   logic [7:0]  prev_ff [5];
   logic [7:0]  devh_ff;
   logic        hob_ff;
   logic [7:0]  blksz_ff;
   logic [7:0]  err_ff;
   logic        errst_ff;
   logic [2:0]  ist_ff;
   logic [2:0]  imask_ff;
   logic        ext_ff;
   logic        fail_ff;
   logic        first_ff;
   logic        cmd_ok_ff;
   logic [16:0] rem_ff;
   logic [7:0]  blk_left_ff;
   logic [7:0]  wcnt_ff;
   logic [47:0] addr_ff;
   logic [47:0] last_ff;
   logic        busy;
   logic        drq;
   logic        cmd_go;
   logic        cmd_ok;
   logic        data_wr;
   logic        sect_ok;
   logic        last_sect;
   logic        blk_end;
   logic [47:0] rep_addr;
   logic [47:0] start_addr;
   logic [16:0] start_cnt;
   logic [47:0] nxt_addr;
   logic [7:0]  status;
   logic [2:0]  ev;

   assign busy    = (state_ff != awcu_pkg::ST_IDLE) & (state_ff != awcu_pkg::ST_XFER);
   assign drq     = (state_ff == awcu_pkg::ST_XFER);
   assign cmd_go  = bus_wr & (idx == awcu_pkg::IDX_CMD) & (state_ff == awcu_pkg::ST_IDLE);
   // low bit masked, retry bit ignored
   assign cmd_ok  = (wb_dat_i[7:1] == awcu_pkg::CMD_WR_SECT[7:1])
                  | (wb_dat_i[7:0] == awcu_pkg::CMD_WR_MULT_FUA);
   // one 16-bit word per data register write
   assign data_wr = bus_wr & wb_sel_i[1] & (idx == awcu_pkg::IDX_DATA) & drq;
   assign sect_ok = (state_ff == awcu_pkg::ST_COMMIT) & med_done_i & ~med_err_i;
   assign last_sect = (rem_ff == 17'h00001);
   // block boundary only matters for the multiple write
   assign blk_end = ~ext_ff | (blk_left_ff <= 8'h01);

   // start address and count from task-file bytes
   always_comb
   begin
      start_addr = {prev_ff[4], prev_ff[3], prev_ff[2], cur_ff[4], cur_ff[3], cur_ff[2]};
      start_cnt  = {1'b0, prev_ff[1], cur_ff[1]};
      if (wb_dat_i[7:0] == awcu_pkg::CMD_WR_MULT_FUA)
      begin
         // current bytes low, previous bytes high
         if (start_cnt == 17'h00000)
            start_cnt = awcu_pkg::SECT_ZERO_EXT;
      end
      else
      begin
         // head nibble is lba 27:24 or head number
         // cylinder bytes are address bits 8-23
         start_addr = {20'h00000, devh_ff[3:0], cur_ff[4], cur_ff[3], cur_ff[2]};
         start_cnt  = {9'h000, cur_ff[1]};
         if (start_cnt == 17'h00000)
            start_cnt = awcu_pkg::SECT_ZERO_STD;
      end
   end

   // next sector address; chs shares the same byte slots as lba
   always_comb
   begin
      nxt_addr = addr_ff + 48'h000000000001;
      if (~ext_ff & ~devh_ff[awcu_pkg::DH_LBA])
      begin
         nxt_addr = addr_ff;
         if (addr_ff[7:0] < awcu_pkg::CHS_SPT)
            nxt_addr[7:0] = addr_ff[7:0] + 8'h01;
         else
         begin
            nxt_addr[7:0] = 8'h01;
            if (addr_ff[27:24] < awcu_pkg::CHS_HEAD_LAST)
               nxt_addr[27:24] = addr_ff[27:24] + 4'h1;
            else
            begin
               nxt_addr[27:24] = 4'h0;
               nxt_addr[23:8]  = addr_ff[23:8] + 16'h0001;
            end
         end
      end
      else if (~ext_ff)
         nxt_addr[47:28] = 20'h00000;
   end

   // extended error shows the failing sector address
   assign rep_addr = (ext_ff & fail_ff) ? addr_ff : last_ff;

   // ----------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state_ff <= awcu_pkg::ST_IDLE;
      else
      begin
         unique case (state_ff)
            awcu_pkg::ST_IDLE:
               if (cmd_go)
                  state_ff <= cmd_ok ? awcu_pkg::ST_PREP : awcu_pkg::ST_FINISH;
            // one busy cycle before each block's data request
            awcu_pkg::ST_PREP:
               state_ff <= awcu_pkg::ST_XFER;
            awcu_pkg::ST_XFER:
               if (data_wr & (wcnt_ff == awcu_pkg::WORDS_LAST))
                  state_ff <= awcu_pkg::ST_COMMIT;
            awcu_pkg::ST_COMMIT:
               // a failing sector ends the command
               if (med_err_i)
                  state_ff <= awcu_pkg::ST_FINISH;
               else if (med_done_i)
               begin
                  // fua commits media before ending status
                  if (last_sect)
                     state_ff <= ext_ff ? awcu_pkg::ST_FLUSH : awcu_pkg::ST_FINISH;
                  else if (blk_end)
                     state_ff <= awcu_pkg::ST_PREP;
                  else
                     state_ff <= awcu_pkg::ST_XFER;
               end
            awcu_pkg::ST_FLUSH:
               if (med_flush_done_i)
                  state_ff <= awcu_pkg::ST_FINISH;
            awcu_pkg::ST_FINISH:
               state_ff <= awcu_pkg::ST_IDLE;
         endcase
      end
   end

   // counters and working address
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ext_ff      <= 1'b0;
         fail_ff     <= 1'b0;
         rem_ff      <= 17'h00000;
         blk_left_ff <= 8'h00;
         wcnt_ff     <= 8'h00;
         addr_ff     <= 48'h000000000000;
         last_ff     <= 48'h000000000000;
      end
      else if (cmd_go)
      begin
         ext_ff      <= (wb_dat_i[7:0] == awcu_pkg::CMD_WR_MULT_FUA);
         fail_ff     <= ~cmd_ok;
         rem_ff      <= start_cnt;
         blk_left_ff <= blksz_ff;
         wcnt_ff     <= 8'h00;
         addr_ff     <= start_addr;
         last_ff     <= start_addr;
      end
      else
      begin
         if (data_wr)
            wcnt_ff <= wcnt_ff + 8'h01;
         if ((state_ff == awcu_pkg::ST_COMMIT) & med_err_i)
            fail_ff <= 1'b1;
         if (sect_ok)
         begin
            rem_ff  <= rem_ff - 17'h00001;
            last_ff <= addr_ff;
            addr_ff <= nxt_addr;
            blk_left_ff <= blk_end ? blksz_ff : blk_left_ff - 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // media side strobes
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         med_wdata_o  <= 16'h0000;
         med_wvalid_o <= 1'b0;
         med_wr_o     <= 1'b0;
         med_lba_o    <= 48'h000000000000;
         med_flush_o  <= 1'b0;
      end
      else
      begin
         med_wvalid_o <= data_wr;
         if (data_wr)
            med_wdata_o <= wb_dat_i[15:0];
         med_wr_o  <= data_wr & (wcnt_ff == awcu_pkg::WORDS_LAST);
         med_lba_o <= addr_ff;
         // flush requested on the last good fua sector
         med_flush_o <= sect_ok & last_sect & ext_ff;
      end
   end

   // ----------------------------------------------------------------
   // task-file registers; host writes ignored while busy
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 5; i++)
         begin
            cur_ff[i]  <= 8'h00;
            prev_ff[i] <= 8'h00;
         end
         devh_ff <= awcu_pkg::RST_DEVH;
      end
      else if (state_ff == awcu_pkg::ST_FINISH)
      begin
         if (cmd_ok_ff)
         begin
            // count left is the sectors not written
            cur_ff[1]  <= rem_ff[7:0];
            prev_ff[1] <= rem_ff[15:8];
            cur_ff[2]  <= rep_addr[7:0];
            prev_ff[2] <= rep_addr[31:24];
            cur_ff[3]  <= rep_addr[15:8];
            prev_ff[3] <= rep_addr[39:32];
            cur_ff[4]  <= rep_addr[23:16];
            prev_ff[4] <= rep_addr[47:40];
            if (~ext_ff)
               devh_ff[3:0] <= rep_addr[27:24];
         end
      end
      else if (bus_wr & ~busy)
      begin
         if ((idx >= awcu_pkg::IDX_FEAT) & (idx <= awcu_pkg::IDX_CYLH))
         begin
            // a second write pushes the first into the previous byte
            cur_ff[3'(idx - awcu_pkg::IDX_FEAT)]  <= wb_dat_i[7:0];
            prev_ff[3'(idx - awcu_pkg::IDX_FEAT)] <= cur_ff[3'(idx - awcu_pkg::IDX_FEAT)];
         end
         if (idx == awcu_pkg::IDX_DEVH)
            devh_ff <= wb_dat_i[7:0];
      end
   end

   // marks a recognised command so an abort leaves the bytes alone
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cmd_ok_ff <= 1'b0;
      else if (cmd_go)
         cmd_ok_ff <= cmd_ok;
   end

   // control, block size and mask registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hob_ff   <= 1'b0;
         blksz_ff <= awcu_pkg::RST_BLKSZ;
         imask_ff <= awcu_pkg::RST_IMASK;
      end
      else if (bus_wr)
      begin
         if (idx == awcu_pkg::IDX_DCTL)
            hob_ff <= wb_dat_i[awcu_pkg::DC_HOB];
         // a zero block size is stored as one, the reset value
         if ((idx == awcu_pkg::IDX_BLKSZ) & ~busy & ~drq)
            blksz_ff <= (wb_dat_i[7:0] == 8'h00) ? awcu_pkg::RST_BLKSZ : wb_dat_i[7:0];
         if (idx == awcu_pkg::IDX_IMASK)
            imask_ff <= wb_dat_i[2:0];
      end
   end

   // ----------------------------------------------------------------
   // error and status
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         err_ff   <= 8'h00;
         errst_ff <= 1'b0;
      end
      else if (cmd_go)
      begin
         err_ff   <= cmd_ok ? 8'h00 : 8'h01 << awcu_pkg::ER_ABT;
         errst_ff <= ~cmd_ok;
      end
      // media failure reported as id not found
      else if ((state_ff == awcu_pkg::ST_COMMIT) & med_err_i)
      begin
         err_ff   <= 8'h01 << awcu_pkg::ER_IDN;
         errst_ff <= 1'b1;
      end
   end

   always_comb
   begin
      status = 8'h00;
      status[awcu_pkg::ST_BSY] = busy;
      status[awcu_pkg::ST_RDY] = 1'b1;
      status[awcu_pkg::ST_DSC] = 1'b1;
      status[awcu_pkg::ST_DRQ] = drq;
      status[awcu_pkg::ST_ERR] = errst_ff & ~busy;
   end

   // ----------------------------------------------------------------
   // interrupts: sticky, write one to clear, set wins
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         first_ff <= 1'b0;
      else if (cmd_go)
         first_ff <= 1'b1;
      else if (state_ff == awcu_pkg::ST_PREP)
         first_ff <= 1'b0;
   end

   always_comb
   begin
      ev = 3'h0;
      // data request interrupt per block, none before the first
      ev[awcu_pkg::IRQ_DRQ] = (state_ff == awcu_pkg::ST_PREP) & ~first_ff;
      // final interrupt only after drq has dropped
      ev[awcu_pkg::IRQ_END] = (state_ff == awcu_pkg::ST_FINISH);
      ev[awcu_pkg::IRQ_ERR] = (state_ff == awcu_pkg::ST_FINISH) & errst_ff;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ist_ff <= 3'h0;
      else if (bus_wr & (idx == awcu_pkg::IDX_ISTAT))
         ist_ff <= (ist_ff & ~wb_dat_i[2:0]) | ev;
      else
         ist_ff <= ist_ff | ev;
   end

   assign irq_o = |(ist_ff & imask_ff);

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rdat_ff <= 32'h00000000;
      else if (bus_req & ~wb_we_i)
      begin
         rdat_ff <= 32'h00000000;
         unique case (idx)
            awcu_pkg::IDX_FEAT:  rdat_ff[7:0] <= err_ff;
            awcu_pkg::IDX_SCNT,
            awcu_pkg::IDX_SNUM,
            awcu_pkg::IDX_CYLL,
            awcu_pkg::IDX_CYLH:
               rdat_ff[7:0] <= hob_ff ? prev_ff[3'(idx - awcu_pkg::IDX_FEAT)]
                                      : cur_ff[3'(idx - awcu_pkg::IDX_FEAT)];
            awcu_pkg::IDX_DEVH:  rdat_ff[7:0] <= devh_ff;
            awcu_pkg::IDX_CMD,
            awcu_pkg::IDX_DCTL:  rdat_ff[7:0] <= status;
            awcu_pkg::IDX_BLKSZ: rdat_ff[7:0] <= blksz_ff;
            awcu_pkg::IDX_ISTAT: rdat_ff[2:0] <= ist_ff;
            awcu_pkg::IDX_IMASK: rdat_ff[2:0] <= imask_ff;
            default:             rdat_ff <= 32'h00000000;
         endcase
      end
   end
endmodule // awcu_top
`default_nettype wire

// file: sim/awcu_checker_assertions.sv
// bound checker for the pio write command unit ports
`timescale 1ns/1ns
`default_nettype none
module awcu_checker (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [5:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        irq_o,
   input wire logic [15:0] med_wdata_o,
   input wire logic        med_wvalid_o,
   input wire logic        med_wr_o,
   input wire logic [47:0] med_lba_o,
   input wire logic        med_done_i,
   input wire logic        med_err_i,
   input wire logic        med_flush_o,
   input wire logic        med_flush_done_i
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_word_data: assert property (med_wvalid_o |-> med_wdata_o == $past(wb_dat_i[15:0])
      && $past(wb_adr_i[5:2]) == 4'h0 && $past(wb_we_i))
      else $error("data word differs from bus write");
   a_wr_pulse: assert property (med_wr_o |=> !med_wr_o)
      else $error("sector strobe longer than one cycle");
   a_wr_quiet: assert property (med_wr_o |=> (!med_wvalid_o) [*3])
      else $error("data accepted while sector commits");
   a_flush_pulse: assert property (med_flush_o |=> !med_flush_o)
      else $error("flush strobe longer than one cycle");
   a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !med_wr_o && !med_flush_o)
      else $error("outputs active after reset");
endmodule // awcu_checker
bind awcu_top awcu_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
   .med_wdata_o(med_wdata_o), .med_wvalid_o(med_wvalid_o), .med_wr_o(med_wr_o),
   .med_lba_o(med_lba_o), .med_done_i(med_done_i), .med_err_i(med_err_i),
   .med_flush_o(med_flush_o), .med_flush_done_i(med_flush_done_i));
`default_nettype wire

// file: sim/awcu_media_model.sv
// media side model: answers sector writes and cache flushes
`timescale 1ns/1ns
`default_nettype none
module awcu_media_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       med_wr_i,
   input  wire logic       med_flush_i,
   input  wire logic       slow_i,
   input  wire logic [7:0] fail_at_i,
   output logic            done_o,
   output logic            err_o,
   output logic            flush_done_o
);
   logic [7:0] seen_ff;
   logic [2:0] wait_ff;
   logic [2:0] fwait_ff;
   // slow answers keep the unit busy longer, stressing its commit wait
   always_ff @(posedge clk_i)
      wait_ff <= rst_i ? 3'h0 : med_wr_i ? (slow_i ? 3'h6 : 3'h1) :
                 (wait_ff != 3'h0) ? wait_ff - 3'h1 : 3'h0;
   always_ff @(posedge clk_i)
      seen_ff <= rst_i ? 8'h00 : seen_ff + 8'(med_wr_i);
   always_ff @(posedge clk_i)
   begin
      done_o <= !rst_i && wait_ff == 3'h1 && seen_ff != fail_at_i;
      err_o  <= !rst_i && wait_ff == 3'h1 && seen_ff == fail_at_i;
   end
   always_ff @(posedge clk_i)
   begin
      fwait_ff     <= rst_i ? 3'h0 : med_flush_i ? 3'h5 :
                      (fwait_ff != 3'h0) ? fwait_ff - 3'h1 : 3'h0;
      flush_done_o <= !rst_i && fwait_ff == 3'h1;
   end
endmodule // awcu_media_model
`default_nettype wire

// file: sim/awcu_top_tb.sv
// self-checking bench for the pio write command unit
`timescale 1ns/1ns
`default_nettype none
module awcu_top_tb;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, slow = 1'b0;
   logic        ack, irq, wvalid, wr, flush, done, err, fdone;
   logic [5:0]  adr = 6'h00;
   logic [3:0]  sel = 4'hf;
   logic [31:0] dat = 32'h0, rng = 32'h1, dat_o;
   logic [15:0] wdata;
   logic [47:0] lba, exp_lba;
   logic [7:0]  fail_at = 8'h00;
   logic [15:0] exp_q [$];
   int          n_errors = 0, compares = 0, n_flush = 0, total = 0;
   awcu_top dut_u (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .irq_o(irq), .med_wdata_o(wdata), .med_wvalid_o(wvalid), .med_wr_o(wr),
      .med_lba_o(lba), .med_done_i(done), .med_err_i(err), .med_flush_o(flush),
      .med_flush_done_i(fdone));
   awcu_media_model med_u (.clk_i(clk), .rst_i(rst), .med_wr_i(wr), .med_flush_i(flush),
      .slow_i(slow), .fail_at_i(fail_at), .done_o(done), .err_o(err), .flush_done_o(fdone));
   initial
   begin
      forever #4 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one classic cycle; released only after the edge that samples ack
   task automatic wb(input logic w, input logic [3:0] i, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= {i, 2'b00};
      dat <= d;
      for (n = 0; n < 20 && ack !== 1'b1; n++)
         @(posedge clk);
      if (n == 20)
      begin
         chk("bus ack", 48'h1, 48'h0);
         finish_test();
      end
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
      logic [31:0] q;
      int n;
      q = {24'h0, ~v};
      for (n = 0; n < 300 && (q[7:0] & m) !== v; n++)
         wb(1'b0, awcu_pkg::IDX_CMD, 32'h0, q);
      if (n == 300)
      begin
         chk("status wait", 48'(v), 48'(q[7:0] & m));
         finish_test();
      end
   endtask
   task automatic tf_rd(output logic [39:0] v);
      logic [31:0] q;
      int k;
      v = 40'h0;
      for (k = 0; k < 5; k++)
      begin
         wb(1'b0, 4'(awcu_pkg::IDX_SCNT + k), 32'h0, q);
         v = {q[7:0], v[39:8]};
      end
   endtask
   task automatic run(input logic [7:0] cmd, input logic [7:0] dh, input logic [15:0] cnt,
                      input logic [47:0] a, input logic [47:0] m, input int ns,
                      input int fail, input int blk);
      logic [31:0] q;
      logic [15:0] tf [4];
      logic [47:0] last;
      logic [39:0] v, e, msk;
      logic        ext;
      int          i;
      int          k;
      ext = (cmd == awcu_pkg::CMD_WR_MULT_FUA);
      tf = '{cnt, {a[31:24], a[7:0]}, {a[39:32], a[15:8]}, {a[47:40], a[23:16]}};
      n_flush = 0;
      exp_lba = m;
      fail_at <= (fail > 0) ? 8'(total + fail) : 8'h00;
      wb(1'b1, awcu_pkg::IDX_BLKSZ, 32'(blk), q);
      for (k = 0; k < 8; k++)
         wb(1'b1, 4'(awcu_pkg::IDX_SCNT + k / 2), 32'(k[0] ? tf[k/2][7:0] : tf[k/2][15:8]), q);
      wb(1'b1, awcu_pkg::IDX_DEVH, 32'(dh), q);
      wb(1'b1, awcu_pkg::IDX_CMD, 32'(cmd), q);
      for (i = 0; i < ns; i++)
      begin
         wait_st(8'h88, 8'h08);
         wb(1'b0, awcu_pkg::IDX_ISTAT, 32'h0, q);
         chk("block interrupt", 48'(i > 0 && i % blk == 0), 48'(q[7:0]));
         wb(1'b1, awcu_pkg::IDX_ISTAT, 32'h1, q);
         for (k = 0; k < 256; k++)
         begin
            q = rnd();
            exp_q.push_back(q[15:0]);
            wb(1'b1, awcu_pkg::IDX_DATA, q, q);
         end
         total++;
         if (i + 1 == fail)
            break;
      end
      wait_st(8'h88, 8'h00);
      last = a + 48'((fail == 0) ? ns - 1 : ext ? fail - 1 : (fail > 1) ? fail - 2 : 0);
      wb(1'b0, awcu_pkg::IDX_CMD, 32'h0, q);
      chk("end status", (fail > 0) ? 48'h51 : 48'h50, 48'(q[7:0]));
      wb(1'b0, awcu_pkg::IDX_FEAT, 32'h0, q);
      if (fail > 0)
         chk("error code", 48'h10, 48'(q[7:0]));
      wb(1'b0, awcu_pkg::IDX_ISTAT, 32'h0, q);
      chk("end interrupt", (fail > 0) ? 48'h6 : 48'h2, 48'(q[7:0]));
      chk("irq level", 48'h1, 48'(irq));
      wb(1'b1, awcu_pkg::IDX_ISTAT, 32'h7, q);
      chk("irq cleared", 48'h0, 48'(irq));
      chk("flush count", 48'(ext && fail == 0), 48'(n_flush));
      e = {dh[7:4], last[27:24], last[23:0], (fail > 0) ? 8'(ns - fail + 1) : 8'h00};
      msk = ext ? 40'h00ffffffff : 40'hffffffffff;
      tf_rd(v);
      chk("task file", 48'(e & msk), 48'(v & msk));
      if (ext)
      begin
         wb(1'b1, awcu_pkg::IDX_DCTL, 32'h80, q);
         tf_rd(v);
         chk("high address", 48'(last[47:24]), 48'(v[31:8]));
         wb(1'b1, awcu_pkg::IDX_DCTL, 32'h0, q);
      end
      $display("test command %h done", cmd);
   endtask
   always @(negedge clk)
   begin
      if (wvalid === 1'b1)
         chk("data word", 48'(exp_q.pop_front()), 48'(wdata));
      if (wr === 1'b1)
      begin
         chk("sector address", exp_lba, lba);
         exp_lba = exp_lba + 48'h1;
      end
      if (flush === 1'b1)
         n_flush++;
   end
   initial
   begin
      logic [31:0] q;
      logic [47:0] a;
      logic [3:0]  ridx [6];
      logic [7:0]  rval [6];
      int          i;
      ridx = '{awcu_pkg::IDX_CMD, awcu_pkg::IDX_DEVH, awcu_pkg::IDX_BLKSZ,
               awcu_pkg::IDX_IMASK, awcu_pkg::IDX_ISTAT, 4'hf};
      rval = '{8'h50, 8'ha0, 8'h01, 8'h00, 8'h00, 8'h00};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 6; i++)
      begin
         wb(1'b0, ridx[i], 32'h0, q);
         chk("reset value", 48'(rval[i]), 48'(q[7:0]));
      end
      $display("test reset values done");
      // unknown code must abort; mask gates the level output
      wb(1'b1, awcu_pkg::IDX_CMD, 32'haa, q);
      wait_st(8'h88, 8'h00);
      wb(1'b0, awcu_pkg::IDX_CMD, 32'h0, q);
      chk("abort status", 48'h51, 48'(q[7:0]));
      wb(1'b0, awcu_pkg::IDX_FEAT, 32'h0, q);
      chk("abort error", 48'h04, 48'(q[7:0]));
      chk("masked irq", 48'h0, 48'(irq));
      wb(1'b1, awcu_pkg::IDX_IMASK, 32'h7, q);
      chk("unmasked irq", 48'h1, 48'(irq));
      wb(1'b1, awcu_pkg::IDX_ISTAT, 32'h6, q);
      chk("cleared irq", 48'h0, 48'(irq));
      $display("test abort done");
      for (i = 0; i < 2; i++)
      begin
         a = 48'(rnd() & 32'h0ffffff0);
         run(8'h30 + 8'(i), {4'he, a[27:24]}, 16'h0002, a, a, 2, 0, 1);
      end
      q = rnd();
      a = {20'h0, 4'h3, q[15:0], 8'h01};
      run(8'h30, 8'ha3, 16'h0002, a, a, 2, 0, 1);
      a = 48'(rnd() & 32'h0ffffff0);
      run(8'h31, {4'he, a[27:24]}, 16'h0003, a, a, 3, 2, 1);
      slow <= 1'b1;
      q = rnd();
      a = {q[15:0], rnd()};
      run(8'hce, 8'he0, 16'h0003, a, a, 3, 0, 2);
      run(8'hce, 8'he0, 16'h0003, a, a, 3, 3, 2);
      finish_test();
   end
endmodule // awcu_top_tb
`default_nettype wire
